// [rtl/emb_pkg.sv]
// constants, encodings and types shared by the emulator event/breakpoint levels
// assumes one 50 MHz emulator clock and a synchronous active-low reset
package emb_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_LEVELS = 2;
    localparam int QUALS_PER_LEVEL = 4;
    localparam int NUM_ADDR_QUALS = 2;
    localparam int NUM_HW_BP = 4;
    localparam int HW_BP_CNT_W = 3;
    localparam int COMPS_PER_LEVEL = 2;
    localparam int REPEAT_W = 16;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int RANGE_W = 16;
    localparam int PRIO_W = 4;
    localparam int PRIO_POS = 12;
    localparam int EXT_SYNC_STAGES = 3;

    // ------------------------------------------------------------------
    // data mask selections and their masks
    // ------------------------------------------------------------------
    localparam logic [1:0] DMASK_LOW = 2'h0;
    localparam logic [1:0] DMASK_HIGH = 2'h1;
    localparam logic [1:0] DMASK_WORD = 2'h2;
    localparam logic [DATA_W-1:0] MASK_LOW = 16'h00ff;
    localparam logic [DATA_W-1:0] MASK_HIGH = 16'hff00;
    localparam logic [DATA_W-1:0] MASK_WORD = 16'hffff;

    // ------------------------------------------------------------------
    // counter values and hardware breakpoint budget
    // ------------------------------------------------------------------
    localparam logic [REPEAT_W-1:0] REPEAT_RST = 16'h0000;
    localparam logic [REPEAT_W-1:0] REPEAT_ONE = 16'h0001;
    localparam logic [HW_BP_CNT_W-1:0] HW_BP_TOTAL = 3'h4;
    localparam logic [HW_BP_CNT_W-1:0] HW_BP_PER_LEVEL = 3'h2;

    // ------------------------------------------------------------------
    // modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EMB_DEP_NONE,
        EMB_DEP_EXT,
        EMB_DEP_OTHER
    } emb_dep_e;

    typedef enum logic [1:0] {
        EMB_OUT_PULSE,
        EMB_OUT_SETCLR,
        EMB_OUT_TRACK
    } emb_out_e;

endpackage

// [rtl/emb_qual.sv]
// one address or data qualifier comparator of an event level
// assumes bus cycle signals are on the emulator clock; the result is combinational
`timescale 1ns/1ns
module emb_qual #(
    parameter bit IS_DATA = 1'b0,
    parameter int ADDR_W = emb_pkg::ADDR_W,
    parameter int DATA_W = emb_pkg::DATA_W,
    parameter int RANGE_W = emb_pkg::RANGE_W
) (
    // configuration
    input wire logic en_i,
    input wire logic [ADDR_W-1:0] addr_val_i,
    input wire logic [RANGE_W-1:0] addr_rng_i,
    input wire logic [DATA_W-1:0] data_val_i,
    input wire logic [1:0] dmask_sel_i,
    input wire logic comb_or_i,
    input wire logic rd_sel_i,
    input wire logic wr_sel_i,
    // observed bus cycle
    input wire logic bus_valid_i,
    input wire logic bus_fetch_i,
    input wire logic bus_write_i,
    input wire logic [ADDR_W-1:0] bus_addr_i,
    input wire logic [DATA_W-1:0] bus_data_i,
    // result
    output logic match_o
);

    logic [ADDR_W-1:0] care;
    logic [DATA_W-1:0] dmask;
    logic addr_hit;
    logic data_hit;
    logic cyc_ok;

    // -----------------------------------------------------------------
    // comparison
    // -----------------------------------------------------------------
    // only the low 64K may be masked, so a range never spans more than that
    assign care = {{(ADDR_W-RANGE_W){1'b1}}, ~addr_rng_i};
    assign addr_hit = ((bus_addr_i ^ addr_val_i) & care) == '0;

    // byte lane selection of the data compare
    always_comb begin
        unique case (dmask_sel_i)
            emb_pkg::DMASK_LOW: dmask = emb_pkg::MASK_LOW;
            emb_pkg::DMASK_HIGH: dmask = emb_pkg::MASK_HIGH;
            default: dmask = emb_pkg::MASK_WORD;
        endcase
    end

    // data values are only seen on writes, reads never satisfy the data part
    assign data_hit = bus_write_i && (((bus_data_i ^ data_val_i) & dmask) == '0);
    assign cyc_ok = (bus_write_i && wr_sel_i) || (!bus_write_i && rd_sel_i);

    // address qualifiers watch fetches, data qualifiers watch read/write cycles
    always_comb begin
        if (IS_DATA) begin
            match_o = en_i && bus_valid_i && !bus_fetch_i && cyc_ok
                && (comb_or_i ? (addr_hit || data_hit) : (addr_hit && data_hit));
        end else begin
            match_o = en_i && bus_valid_i && bus_fetch_i && addr_hit;
        end
    end

endmodule

// [rtl/emb_event_levels.sv]
// two-level event and breakpoint logic of the in-circuit emulator
// assumes bus cycles, run start and settings come from logic on sys_clk_i;
// only the external event pin is asynchronous and is synchronised here
// Notes on behaviour
// - data qualifier matches one address or a masked range up to 64K; pair ORed
// - data qualifier ANDs or ORs address match with a write-only data compare
// - data mask picks low byte 00ff, high byte ff00 or word ffff
// - data qualifier events offer immediate halt only, never halt before execute
// - each level owns a 16-bit repeat counter, largest count ffff
// - event fires after the condition was true repeat-count times
// - a repeat count of zero never fires the level
// - dependency on other level or external event input; default independent
// - priority gating breaks only when status word level is below monitor level
// - disabled qualifiers never match; all four off reports the level disabled
// - read and write options restrict which cycles a data qualifier sees
// - four hardware breakpoints share the level comparators
// - each level in use removes two hardware breakpoints
// - resources checked at run or step start; shortage is reported
// - external event input is synchronised, then used latched or direct
// - set/clear mode: output on at turn-on event, off at turn-off event
// - tracking mode: output follows condition with turn-on selected, per cycle
`timescale 1ns/1ns
module emb_event_levels #(
    parameter int ADDR_W = emb_pkg::ADDR_W,
    parameter int DATA_W = emb_pkg::DATA_W,
    parameter int NL = emb_pkg::NUM_LEVELS,
    parameter int NQ = emb_pkg::QUALS_PER_LEVEL,
    parameter int NB = emb_pkg::NUM_HW_BP
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // observed target bus cycle
    input wire logic bus_valid_i,
    input wire logic bus_fetch_i,
    input wire logic bus_write_i,
    input wire logic [ADDR_W-1:0] bus_addr_i,
    input wire logic [DATA_W-1:0] bus_data_i,
    input wire logic [DATA_W-1:0] cpu_status_word_i,
    // execution control and external pin
    input wire logic run_start_i,
    input wire logic ext_event_i,
    input wire logic ext_latched_i,
    // qualifier settings, index level*NQ+k, k 0..1 address, 2..3 data
    input wire logic [NL*NQ-1:0] qual_en_i,
    input wire logic [NL*NQ-1:0][ADDR_W-1:0] qual_addr_i,
    input wire logic [NL*NQ-1:0][emb_pkg::RANGE_W-1:0] qual_rng_i,
    input wire logic [NL*NQ-1:0][DATA_W-1:0] qual_data_i,
    input wire logic [NL*NQ-1:0][1:0] qual_dmask_i,
    input wire logic [NL*NQ-1:0] qual_or_i,
    input wire logic [NL*NQ-1:0] qual_rd_i,
    input wire logic [NL*NQ-1:0] qual_wr_i,
    // level settings
    input wire logic [NL-1:0][emb_pkg::REPEAT_W-1:0] repeat_count_i,
    input wire logic [NL-1:0] repeat_reload_i,
    input wire emb_pkg::emb_dep_e [NL-1:0] dep_sel_i,
    input wire logic [NL-1:0] prio_en_i,
    input wire logic [emb_pkg::PRIO_W-1:0] monitor_prio_i,
    input wire logic [NL-1:0] halt_before_sel_i,
    input wire logic [NL-1:0] halt_now_sel_i,
    input wire logic [NL-1:0] out_on_sel_i,
    input wire logic [NL-1:0] out_off_sel_i,
    input wire emb_pkg::emb_out_e out_mode_i,
    // hardware breakpoints
    input wire logic [NB-1:0] hw_bp_en_i,
    input wire logic [NB-1:0][ADDR_W-1:0] hw_bp_addr_i,
    // results
    output logic halt_before_o,
    output logic immediate_halt_o,
    output logic event_out_o,
    output logic [NL-1:0] level_event_o,
    output logic [NL-1:0] level_enabled_o,
    output logic [emb_pkg::HW_BP_CNT_W-1:0] hw_bp_avail_o,
    output logic resource_fail_o
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [emb_pkg::EXT_SYNC_STAGES-1:0] ext_sync;
        logic ext_lvl;
        logic ext_latch;
        logic [NL-1:0][emb_pkg::REPEAT_W-1:0] cnt;
        logic [NL-1:0] fired;
        logic [NL-1:0] lvl_evt;
        logic [NL-1:0] lvl_en;
        logic halt_before;
        logic halt_now;
        logic evt_out;
        logic [emb_pkg::HW_BP_CNT_W-1:0] avail;
        logic res_fail;
    } emb_state_s;

    emb_state_s st;
    emb_state_s next_st;

    logic [NL*NQ-1:0] qmatch;
    logic [NB-1:0] bp_match;

    // -----------------------------------------------------------------
    // comparators, shared by levels and hardware breakpoints
    // -----------------------------------------------------------------
    // one loop builds all level qualifiers; k >= 2 are the data kind
    for (genvar q = 0; q < NL*NQ; q++) begin : g_qual
        emb_qual #(
            .IS_DATA((q % NQ) >= emb_pkg::NUM_ADDR_QUALS),
            .ADDR_W(ADDR_W),
            .DATA_W(DATA_W),
            .RANGE_W(emb_pkg::RANGE_W)
        ) u_qual (
            .en_i(qual_en_i[q]),
            .addr_val_i(qual_addr_i[q]),
            .addr_rng_i(qual_rng_i[q]),
            .data_val_i(qual_data_i[q]),
            .dmask_sel_i(qual_dmask_i[q]),
            .comb_or_i(qual_or_i[q]),
            .rd_sel_i(qual_rd_i[q]),
            .wr_sel_i(qual_wr_i[q]),
            .bus_valid_i(bus_valid_i),
            .bus_fetch_i(bus_fetch_i),
            .bus_write_i(bus_write_i),
            .bus_addr_i(bus_addr_i),
            .bus_data_i(bus_data_i),
            .match_o(qmatch[q])
        );
    end

    // hardware breakpoints are exact fetch-address comparators
    for (genvar b = 0; b < NB; b++) begin : g_bp
        emb_qual #(
            .IS_DATA(1'b0),
            .ADDR_W(ADDR_W),
            .DATA_W(DATA_W),
            .RANGE_W(emb_pkg::RANGE_W)
        ) u_bp (
            .en_i(hw_bp_en_i[b]),
            .addr_val_i(hw_bp_addr_i[b]),
            .addr_rng_i('0),
            .data_val_i('0),
            .dmask_sel_i(emb_pkg::DMASK_WORD),
            .comb_or_i(1'b0),
            .rd_sel_i(1'b0),
            .wr_sel_i(1'b0),
            .bus_valid_i(bus_valid_i),
            .bus_fetch_i(bus_fetch_i),
            .bus_write_i(bus_write_i),
            .bus_addr_i(bus_addr_i),
            .bus_data_i(bus_data_i),
            .match_o(bp_match[b])
        );
    end

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        logic [NL-1:0] trig;
        logic [NL-1:0] addr_trig;
        logic [NL-1:0] dep_ok;
        logic [NL-1:0] cond;
        logic [NL-1:0] evt;
        logic [NL-1:0] track;
        logic prio_ok;
        logic brk_before;
        logic brk_now;
        logic ext_use;
        logic [emb_pkg::HW_BP_CNT_W-1:0] used;
        logic [emb_pkg::HW_BP_CNT_W-1:0] want;
        logic [emb_pkg::HW_BP_CNT_W-1:0] avail;
        trig = '0;
        addr_trig = '0;
        dep_ok = '0;
        cond = '0;
        evt = '0;
        track = '0;
        brk_before = 1'b0;
        brk_now = 1'b0;
        used = '0;
        want = '0;
        prio_ok = 1'b0;
        ext_use = 1'b0;
        avail = '0;
        next_st = st;

        // three-stage synchroniser; the level moves only when stages 2 and 3 agree
        next_st.ext_sync = {st.ext_sync[1:0], ext_event_i};
        if (st.ext_sync[1] == st.ext_sync[2]) begin
            next_st.ext_lvl = st.ext_sync[2];
        end
        ext_use = ext_latched_i ? st.ext_latch : st.ext_lvl;

        // interrupt level sits in the top bits of the status word
        prio_ok = cpu_status_word_i[emb_pkg::PRIO_POS +: emb_pkg::PRIO_W] < monitor_prio_i;

        for (int l = 0; l < NL; l++) begin
            trig[l] = |qmatch[l*NQ +: NQ];
            addr_trig[l] = |qmatch[l*NQ +: emb_pkg::NUM_ADDR_QUALS];
            next_st.lvl_en[l] = |qual_en_i[l*NQ +: NQ];
            unique case (dep_sel_i[l])
                emb_pkg::EMB_DEP_EXT: dep_ok[l] = ext_use;
                emb_pkg::EMB_DEP_OTHER: dep_ok[l] = st.fired[(l + 1) % NL];
                default: dep_ok[l] = 1'b1;
            endcase
            cond[l] = trig[l] && dep_ok[l];
            track[l] = cond[l] && out_on_sel_i[l];

            // counter at zero is idle, so a zero count never fires
            if (run_start_i) begin
                next_st.cnt[l] = repeat_count_i[l];
            end else if (cond[l] && (st.cnt[l] != emb_pkg::REPEAT_RST)) begin
                if (st.cnt[l] == emb_pkg::REPEAT_ONE) begin
                    evt[l] = 1'b1;
                    next_st.cnt[l] = repeat_reload_i[l] ? repeat_count_i[l]
                        : emb_pkg::REPEAT_RST;
                end else begin
                    next_st.cnt[l] = st.cnt[l] - emb_pkg::REPEAT_ONE;
                end
            end

            // halts honour the priority gate; data-caused events halt immediately
            if (evt[l] && (!prio_en_i[l] || prio_ok)) begin
                if (halt_before_sel_i[l] && addr_trig[l]) begin
                    brk_before = 1'b1;
                end
                if (halt_now_sel_i[l] || (halt_before_sel_i[l] && !addr_trig[l])) begin
                    brk_now = 1'b1;
                end
            end
            if (next_st.lvl_en[l]) begin
                used = used + emb_pkg::HW_BP_PER_LEVEL;
            end
            if (run_start_i) begin
                next_st.fired[l] = 1'b0;
            end else if (evt[l]) begin
                next_st.fired[l] = 1'b1;
            end
        end
        next_st.lvl_evt = evt;

        // external latch is rearmed at each run start; a high synchronised level wins over it
        if (st.ext_lvl) begin
            next_st.ext_latch = 1'b1;
        end else if (run_start_i) begin
            next_st.ext_latch = 1'b0;
        end

        // breakpoint budget: levels in use take comparators first
        avail = (used >= emb_pkg::HW_BP_TOTAL) ? '0 : emb_pkg::HW_BP_TOTAL - used;
        for (int b = 0; b < NB; b++) begin
            want = want + {{(emb_pkg::HW_BP_CNT_W-1){1'b0}}, hw_bp_en_i[b]};
        end
        if (run_start_i) begin
            next_st.avail = avail;
            next_st.res_fail = want > avail;
        end
        // only the first st.avail breakpoints own a comparator during the run
        for (int b = 0; b < NB; b++) begin
            if (bp_match[b] && (b < int'(st.avail))) begin
                brk_before = 1'b1;
            end
        end
        next_st.halt_before = brk_before;
        next_st.halt_now = brk_now;

        // event output modes; in set/clear a simultaneous on and off turns on
        unique case (out_mode_i)
            emb_pkg::EMB_OUT_SETCLR: begin
                if (|(evt & out_on_sel_i)) begin
                    next_st.evt_out = 1'b1;
                end else if (|(evt & out_off_sel_i)) begin
                    next_st.evt_out = 1'b0;
                end
            end
            emb_pkg::EMB_OUT_TRACK: next_st.evt_out = |track;
            default: next_st.evt_out = |evt;
        endcase
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign halt_before_o = st.halt_before;
    assign immediate_halt_o = st.halt_now;
    assign event_out_o = st.evt_out;
    assign level_event_o = st.lvl_evt;
    assign level_enabled_o = st.lvl_en;
    assign hw_bp_avail_o = st.avail;
    assign resource_fail_o = st.res_fail;

endmodule

// [dv/emb_checker.sv]
// assertions on the ports of the two-level event and breakpoint logic
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ns
module emb_checker (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // watched inputs
    input wire logic bus_valid_i,
    input wire logic bus_fetch_i,
    input wire logic run_start_i,
    input wire logic [7:0] qual_en_i,
    input wire logic [3:0] hw_bp_en_i,
    input wire logic [1:0][15:0] repeat_count_i,
    input wire logic [1:0] out_on_sel_i,
    input wire emb_pkg::emb_out_e out_mode_i,
    // watched outputs
    input wire logic halt_before_o,
    input wire logic immediate_halt_o,
    input wire logic event_out_o,
    input wire logic [1:0] level_event_o,
    input wire logic [1:0] level_enabled_o,
    input wire logic [2:0] hw_bp_avail_o,
    input wire logic resource_fail_o
);
    logic use0, use1, on_any, zero_run;
    logic [2:0] bp_cnt;
    // helper terms, so that past values are taken of plain signals
    assign use0 = |qual_en_i[3:0];
    assign use1 = |qual_en_i[7:4];
    assign on_any = |out_on_sel_i;
    assign bp_cnt = 3'($countones(hw_bp_en_i));
    // level 0 armed with a zero count; reset leaves every counter empty
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            zero_run <= 1'b1;
        end else if (run_start_i) begin
            zero_run <= (repeat_count_i[0] == 16'h0000);
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    level_on_a: assert property ($past(rstn_i) |-> level_enabled_o == {$past(use1),
        $past(use0)}) else $error("level enable flag wrong");
    bp_avail_a: assert property ($past(run_start_i) && $past(rstn_i) |->
        hw_bp_avail_o == 3'h4 - {$past(use0), 1'b0} - {$past(use1), 1'b0})
        else $error("breakpoint count wrong");
    res_fail_a: assert property ($past(run_start_i) && $past(rstn_i) |->
        resource_fail_o == ($past(bp_cnt) > hw_bp_avail_o)) else $error("shortage flag wrong");
    res_hold_a: assert property ($past(rstn_i) && !$past(run_start_i) |->
        $stable(hw_bp_avail_o) && $stable(resource_fail_o)) else $error("resources moved");
    zero_cnt_a: assert property (zero_run && !$past(run_start_i) |-> !level_event_o[0])
        else $error("zero count fired");
    ev_cause_a: assert property (level_event_o[0] |-> $past(bus_valid_i))
        else $error("event without bus cycle");
    halt_fetch_a: assert property (halt_before_o |-> $past(bus_valid_i) && $past(bus_fetch_i))
        else $error("halt before on a data cycle");
    halt_cause_a: assert property (immediate_halt_o |-> $past(bus_valid_i))
        else $error("halt without bus cycle");
    track_out_a: assert property (out_mode_i == emb_pkg::EMB_OUT_TRACK &&
        $past(out_mode_i) == emb_pkg::EMB_OUT_TRACK && event_out_o |->
        $past(bus_valid_i) && $past(on_any)) else $error("tracking output wrong");
    setclr_hold_a: assert property ($past(rstn_i) && out_mode_i == emb_pkg::EMB_OUT_SETCLR &&
        $past(out_mode_i) == emb_pkg::EMB_OUT_SETCLR && !$past(bus_valid_i) |->
        $stable(event_out_o)) else $error("set/clear output moved");
endmodule
bind emb_event_levels emb_checker i_chk (.*);

// [dv/emb_bus_model.sv]
// target bus partner: presents one observed bus cycle per bench request
// assumes requests change just after a rising edge of sys_clk_i
`timescale 1ns/1ns
module emb_bus_model (
    // clock
    input wire logic sys_clk_i,
    // bench request
    input wire logic req_i,
    input wire logic fetch_i,
    input wire logic write_i,
    input wire logic [23:0] addr_i,
    input wire logic [15:0] data_i,
    // observed cycle
    output logic bus_valid_o,
    output logic bus_fetch_o,
    output logic bus_write_o,
    output logic [23:0] bus_addr_o,
    output logic [15:0] bus_data_o
);
    initial begin
        {bus_valid_o, bus_fetch_o, bus_write_o, bus_addr_o, bus_data_o} = '0;
    end
    // idle lines keep toggling, so a stale value never passes for a cycle
    always @(posedge sys_clk_i) begin
        bus_valid_o <= req_i;
        if (req_i) begin
            bus_fetch_o <= fetch_i;
            bus_write_o <= write_i;
            bus_addr_o <= addr_i;
            bus_data_o <= data_i;
        end else begin
            bus_fetch_o <= ~bus_fetch_o;
            bus_write_o <= ~bus_write_o;
            bus_addr_o <= ~bus_addr_o;
            bus_data_o <= ~bus_data_o;
        end
    end
endmodule

// [dv/test_emb_event_levels.sv]
// self-checking bench of the event levels against a cycle model of level 0
// assumes the bus partner model and the bound checker are compiled first
`timescale 1ns/1ns
module test_emb_event_levels;
    logic sys_clk_i = 0, rstn_i = 0, run_start_i = 0, ext_event_i = 0, ext_latched_i = 0;
    logic req = 0, fetch = 0, write = 0, armed = 0;
    logic [23:0] addr = '0, qa;
    logic [15:0] data = '0, cpu_status_word_i = '0;
    logic [7:0] qual_en_i = '0, qual_or_i = '0, qual_rd_i = '0, qual_wr_i = '0;
    logic [7:0][23:0] qual_addr_i = '0;
    logic [7:0][15:0] qual_rng_i = '0, qual_data_i = '0;
    logic [7:0][1:0] qual_dmask_i = '0;
    logic [1:0][15:0] repeat_count_i = '0;
    logic [1:0] repeat_reload_i = 0, prio_en_i = 0, halt_before_sel_i = 0, halt_now_sel_i = 0;
    logic [1:0] out_on_sel_i = 0, out_off_sel_i = 0;
    logic [3:0] monitor_prio_i = 0, hw_bp_en_i = 0;
    logic [3:0][23:0] hw_bp_addr_i = '0;
    emb_pkg::emb_dep_e [1:0] dep_sel_i = '{default: emb_pkg::EMB_DEP_NONE};
    emb_pkg::emb_out_e out_mode_i = emb_pkg::EMB_OUT_PULSE;
    wire logic bus_valid_i, bus_fetch_i, bus_write_i;
    wire logic [23:0] bus_addr_i;
    wire logic [15:0] bus_data_i;
    wire logic halt_before_o, immediate_halt_o, event_out_o, resource_fail_o;
    wire logic [1:0] level_event_o, level_enabled_o;
    wire logic [2:0] hw_bp_avail_o;
    logic ah, ad, dd, dh, c, ev, g, e_ev = 0, e_hb = 0, e_ih = 0, e_out = 0;
    logic [15:0] dm;
    logic [31:0] k;
    int cnt = 0, num_errors = 0, num_checks = 0, seed = 4234, ph, n;

    always #10 sys_clk_i = ~sys_clk_i;
    emb_bus_model i_bus (.sys_clk_i(sys_clk_i), .req_i(req), .fetch_i(fetch), .write_i(write),
        .addr_i(addr), .data_i(data), .bus_valid_o(bus_valid_i), .bus_fetch_o(bus_fetch_i),
        .bus_write_o(bus_write_i), .bus_addr_o(bus_addr_i), .bus_data_o(bus_data_i));
    emb_event_levels i_dut (.*);

    // ------------------------------------------------------------
    // reference model of level 0, registered like the outputs
    // ------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        ah = qual_en_i[0] && bus_valid_i && bus_fetch_i
            && ((bus_addr_i ^ qual_addr_i[0]) & ~{8'h00, qual_rng_i[0]}) == 0;
        ad = ((bus_addr_i ^ qual_addr_i[2]) & ~{8'h00, qual_rng_i[2]}) == 0;
        dm = qual_dmask_i[2] == 0 ? 16'h00ff : qual_dmask_i[2] == 1 ? 16'hff00 : 16'hffff;
        dd = bus_write_i && ((bus_data_i ^ qual_data_i[2]) & dm) == 0;
        dh = qual_en_i[2] && bus_valid_i && !bus_fetch_i
            && (bus_write_i ? qual_wr_i[2] : qual_rd_i[2])
            && (qual_or_i[2] ? ad || dd : ad && dd);
        // level 1 never fires here, so depending on it blocks level 0
        c = (ah || dh) && (dep_sel_i[0] == emb_pkg::EMB_DEP_NONE
            || dep_sel_i[0] == emb_pkg::EMB_DEP_EXT && ext_event_i);
        ev = 0;
        g = !prio_en_i[0] || cpu_status_word_i[15:12] < monitor_prio_i;
        if (run_start_i) begin
            cnt = repeat_count_i[0];
        end else if (c && cnt > 0) begin
            cnt--;
            ev = cnt == 0;
            if (ev && repeat_reload_i[0]) cnt = repeat_count_i[0];
        end
        e_ev = ev;
        e_hb = ev && g && halt_before_sel_i[0] && ah
            || hw_bp_en_i[0] && bus_valid_i && bus_fetch_i && bus_addr_i == hw_bp_addr_i[0];
        e_ih = ev && g && (halt_now_sel_i[0] || halt_before_sel_i[0] && !ah);
        if (out_mode_i == emb_pkg::EMB_OUT_TRACK) e_out = c && out_on_sel_i[0];
        else if (out_mode_i == emb_pkg::EMB_OUT_PULSE) e_out = ev;
        else if (ev && out_on_sel_i[0]) e_out = 1;
        else if (ev && out_off_sel_i[0]) e_out = 0;
        if (!rstn_i) {cnt, e_ev, e_hb, e_ih, e_out} = '0;
    end

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // compare every settled cycle from the fourth clock edge on, while the first reset is still held
    always @(negedge sys_clk_i) begin
        if (armed) begin
            chk(level_event_o[0], e_ev);
            chk(level_event_o[1], 1'b0);
            chk(halt_before_o, e_hb);
            chk(immediate_halt_o, e_ih);
            chk(event_out_o, e_out);
        end
    end
    task go;
        run_start_i <= 1;
        @(posedge sys_clk_i);
        run_start_i <= 0;
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        num_errors++;
        give_verdict;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk_i);
        armed <= 1;
        // random phases: address or data qualifier, every output mode; data phases see only the high byte and word masks
        for (ph = 0; ph < 12; ph++) begin
            k = $random(seed);
            qa = 24'($random(seed));
            rstn_i <= 0;
            n = $random(seed);
            qual_rng_i <= {8{n[3] ? 16'h000f : 16'h0000}};
            hw_bp_en_i <= {3'h0, n[0]};
            hw_bp_addr_i <= {4{qa}};
            {ext_event_i, ext_latched_i} <= {n[1], n[2]};
            dep_sel_i[0] <= emb_pkg::emb_dep_e'(ph / 4 == 1 ? 2'h1 : ph == 11 ? 2'h2 : 2'h0);
            qual_en_i <= ph % 2 ? 8'h04 : 8'h01;
            qual_addr_i <= {8{qa}};
            qual_data_i <= {8{k[31:16]}};
            qual_dmask_i <= {8{2'(ph % 4)}};
            {qual_or_i, qual_rd_i, qual_wr_i} <= {{8{k[0]}}, {8{k[1]}}, {8{k[2] | k[3]}}};
            repeat_count_i <= {16'h0000, 16'(ph % 5)};
            {repeat_reload_i, prio_en_i} <= {1'b0, k[4], 1'b0, k[5]};
            {cpu_status_word_i, monitor_prio_i} <= {k[11:8], 12'h000, k[15:12]};
            halt_before_sel_i <= {1'b0, k[6] | ph % 2 == 0};
            halt_now_sel_i <= {1'b0, ph % 2 == 1 && !k[6]};
            out_mode_i <= emb_pkg::emb_out_e'(ph % 3);
            {out_on_sel_i, out_off_sel_i} <= {1'b0, k[7] | ph % 3 == 0, 1'b0, k[8]};
            @(posedge sys_clk_i);
            rstn_i <= 1;
            // let the event pin settle through its synchroniser before the run
            repeat (4) @(posedge sys_clk_i);
            go;
            repeat (30) begin
                k = $random(seed);
                req <= k[0] | k[1];
                fetch <= ph % 2 ? k[2] & k[3] : k[2] | k[3];
                write <= k[4];
                addr <= k[5] | k[6] ? qa ^ (k[9] ? {20'h0, k[13:10]} : 24'h0)
                    : 24'($random(seed));
                data <= qual_data_i[2] ^ ((k[8] ? 16'hff00 : 16'h00ff) & {16{k[7]}});
                @(posedge sys_clk_i);
            end
            req <= 0;
            repeat (4) @(posedge sys_clk_i);
        end
        // breakpoint resources for every level use and breakpoint count
        for (ph = 0; ph < 4; ph++) begin
            for (n = 0; n < 5; n++) begin
                qual_en_i <= {3'h0, ph[1], 3'h0, ph[0]};
                hw_bp_en_i <= 4'((1 << n) - 1);
                hw_bp_addr_i <= {4{24'($random(seed))}};
                go;
                @(negedge sys_clk_i);
                chk(hw_bp_avail_o, 4'(4 - 2 * (ph % 2 + ph / 2)));
                chk(resource_fail_o, n > 4 - 2 * (ph % 2 + ph / 2));
                chk(level_enabled_o, 4'(ph));
                @(posedge sys_clk_i);
            end
        end
        give_verdict;
    end
endmodule
